// *** ddc_pkg.sv ***
// shared constants and types of the dual channel converter command decoder
package ddc_pkg;

  // frame layout
  localparam int             FRAME_BITS      = 24;
  localparam int             DATA_W          = 16;
  localparam int             PD_W            = 2;
  localparam int             CNT_W           = 5;
  localparam logic [4:0]     CNT_LAST        = 5'(FRAME_BITS - 1);
  localparam logic [4:0]     CNT_ZERO        = 5'h00;

  // control byte field positions
  localparam int             POS_RSV_HI      = 23;
  localparam int             POS_RSV_LO      = 22;
  localparam int             POS_LOAD_CHAN_B = 21;
  localparam int             POS_LOAD_CHAN_A = 20;
  localparam int             POS_DONT_CARE   = 19;
  localparam int             POS_BUF_SEL     = 18;
  localparam int             POS_PCODE_HI    = 17;
  localparam int             POS_PCODE_LO    = 16;

  // buffer select encoding
  localparam logic           SEL_CHAN_A      = 1'b0;
  localparam logic           SEL_CHAN_B      = 1'b1;

  // power codes per channel
  localparam logic [1:0]     PD_NORMAL       = 2'h0;
  localparam logic [1:0]     PD_PULL_1K      = 2'h1;
  localparam logic [1:0]     PD_PULL_100K    = 2'h2;
  localparam logic [1:0]     PD_HIGH_Z       = 2'h3;

  // reset values of buffers and channel registers
  localparam logic [15:0]    RST_CODE        = 16'h0000;
  localparam logic [1:0]     RST_PCODE       = PD_NORMAL;

  // data path buffering
  localparam int             FIFO_DEPTH      = 8;

  // link tracker states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_LOCK  = 3'b100
  } ddc_lnk_st_t;

endpackage : ddc_pkg

// *** ddc_fifo.sv ***
// small synchronous frame fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module ddc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
  } ddc_fifo_st_t;

  ddc_fifo_st_t q;
  ddc_fifo_st_t n;
  logic         do_wr;
  logic         do_rd;

  // honest flags straight from the occupancy count
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // pointers wrap explicitly so any depth works, not only powers of two
  always_comb begin
    n = q;
    if (do_wr) begin
      n.mem[q.wr] = in_data;
      n.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    end
    if (do_rd) begin
      n.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    end
    case ({do_wr, do_rd})
      2'b10:   n.cnt = q.cnt + CW'(1);
      2'b01:   n.cnt = q.cnt - CW'(1);
      default: n.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // a write that meets a full fifo leaves the count alone
  property p_fifo_no_overfill;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.cnt == CW'(DEPTH)) && !do_rd |=> (q.cnt == CW'(DEPTH)) && !$past(in_ready);
  endproperty
  a_fifo_no_overfill: assert property (p_fifo_no_overfill)
    else $error("fifo count moved while full and not drained");

endmodule : ddc_fifo

`default_nettype wire

// *** ddc_core.sv ***
// serial command decoder core of a dual channel 16 bit converter
// Functional notes
// - sample data msb first on sclk falls
// - freeze shifter after 24th fall
// - buffer select: zero is A, one B
// - load bits pick channels to update
// - nonzero power code ignores data bits
// - each load uses its own buffer
// - power codes: normal, 1k, 100k, high-z
// - zero code keeps channel amplifier driving
// - power-down needs buffer write then load
// - channels power down independently or together
// - wake needs zero code, data, load
// - shutdown asserted while power-down active
// - act on 24th fall, not select rise
// - early select rise clears shifter, count
// - aborted frame changes nothing stored
// - channel registers zero at power-up
// - outputs zero-scale until loaded
// - only a load changes channel output
`timescale 1ns/10ps
`default_nettype none

module ddc_core
  import ddc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // serial link pins, asynchronous to clk_sys
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        sdin,
  // update control
  input  wire logic        upd_hold,
  // channel a converter controls
  output logic [15:0]      dac_code_a,
  output logic [1:0]       pd_mode_a,
  output logic             shutdown_a,
  // channel b converter controls
  output logic [15:0]      dac_code_b,
  output logic [1:0]       pd_mode_b,
  output logic             shutdown_b,
  // status
  output logic             frame_done,
  output logic             frame_drop
);

  typedef struct packed {
    logic [2:0]        sclk_sy;   // [0] first stage, [2] edge history
    logic [2:0]        csn_sy;
    logic [1:0]        din_sy;
    ddc_lnk_st_t       st;
    logic [4:0]        cnt;
    logic [23:0]       shf;
    logic              push;
    logic              done;
    logic              drop;
    logic [1:0][15:0]  buf_data;
    logic [1:0][1:0]   buf_pd;
    logic [1:0][15:0]  dac_code;
    logic [1:0][1:0]   mode;
    logic [1:0]        shdn;
  } ddc_core_st_t;

  ddc_core_st_t      q;
  ddc_core_st_t      n;

  // link edge helpers, all from second stage onward
  logic              sclk_fall;
  logic              csn_low;
  logic              csn_fall;
  logic              din_s;

  // fifo handshake
  logic              fin_ready;
  logic              fout_valid;
  logic [23:0]       fout_data;
  logic              pop;

  // decoded control byte of the frame at the fifo head
  logic              load_chan_a_bit;
  logic              load_chan_b_bit;
  logic              power_code_bit0;
  logic              power_code_bit1;
  logic              buf_sel;
  logic [1:0]        pcode;
  logic [15:0]       fdata;
  logic [1:0]        load_vec;

  // next buffer contents as seen by a load in the same frame
  logic [1:0][15:0]  nxt_data;
  logic [1:0][1:0]   nxt_pd;

  // edge detection looks only at stages two and three of each synchroniser
  assign sclk_fall = q.sclk_sy[2] & ~q.sclk_sy[1];
  assign csn_low   = ~q.csn_sy[1];
  assign csn_fall  = q.csn_sy[2] & ~q.csn_sy[1];
  assign din_s     = q.din_sy[1];

  // field split of the head frame
  assign load_chan_a_bit = fout_data[POS_LOAD_CHAN_A];
  assign load_chan_b_bit = fout_data[POS_LOAD_CHAN_B];
  assign power_code_bit0 = fout_data[POS_PCODE_LO];
  assign power_code_bit1 = fout_data[POS_PCODE_HI];
  assign buf_sel         = fout_data[POS_BUF_SEL];
  assign pcode           = {power_code_bit1, power_code_bit0};
  assign fdata           = fout_data[DATA_W-1:0];
  assign load_vec        = {load_chan_b_bit, load_chan_a_bit};

  // reserved bits are not checked; a host that sets them gets a decoded frame anyway
  assign pop = fout_valid && !upd_hold;

  // whole frames wait here so a held decoder loses link traffic only once DEPTH frames are queued
  ddc_fifo #(
    .W     (FRAME_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (q.push),
    .in_ready  (fin_ready),
    .in_data   (q.shf),
    .out_valid (fout_valid),
    .out_ready (!upd_hold),
    .out_data  (fout_data)
  );

  // next state: link tracker, then buffer write and channel load
  always_comb begin
    n        = q;
    nxt_data = q.buf_data;
    nxt_pd   = q.buf_pd;
    n.sclk_sy = {q.sclk_sy[1:0], sclk};
    n.csn_sy  = {q.csn_sy[1:0], sync_n};
    n.din_sy  = {q.din_sy[0], sdin};
    n.push    = 1'b0;
    n.done    = 1'b0;
    n.drop    = q.push && !fin_ready;

    case (q.st)
      ST_IDLE: begin
        // a new frame only opens on a fresh fall of select
        if (csn_fall) begin
          n.st  = ST_SHIFT;
          n.cnt = sclk_fall ? 5'h01 : CNT_ZERO;
          n.shf = sclk_fall ? {23'h000000, din_s} : 24'h000000;
        end
      end
      ST_SHIFT: begin
        if (!csn_low) begin
          // early rise: drop the partial frame and nothing else
          n.st  = ST_IDLE;
          n.cnt = CNT_ZERO;
          n.shf = 24'h000000;
        end else if (sclk_fall) begin
          n.shf = {q.shf[22:0], din_s};
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == CNT_LAST) begin
            n.st   = ST_LOCK;
            n.push = 1'b1;
          end
        end
      end
      ST_LOCK: begin
        // further clocks are ignored; select may stay low or rise
        if (!csn_low) begin
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st  = ST_IDLE;
        n.cnt = CNT_ZERO;
      end
    endcase

    // buffer write: a power command keeps the stored sample untouched
    for (int ch = 0; ch < 2; ch++) begin
      if (pop && (buf_sel == ch[0])) begin
        nxt_pd[ch] = pcode;
        if (pcode == PD_NORMAL) begin
          nxt_data[ch] = fdata;
        end
      end
    end
    n.buf_data = nxt_data;
    n.buf_pd   = nxt_pd;

    // load: each addressed channel copies its own buffer, both at once if asked
    for (int ch = 0; ch < 2; ch++) begin
      if (pop && load_vec[ch]) begin
        n.dac_code[ch] = nxt_data[ch];
        n.mode[ch]     = nxt_pd[ch];
        n.shdn[ch]     = (nxt_pd[ch] != PD_NORMAL);
      end
    end
    n.done = pop;
  end

  // power-up puts zero codes and normal mode everywhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.csn_sy   <= 3'h7;
      q.st       <= ST_IDLE;
    end else begin
      q          <= n;
    end
  end

  // outputs all come straight from flip-flops
  assign dac_code_a = q.dac_code[0];
  assign dac_code_b = q.dac_code[1];
  assign pd_mode_a  = q.mode[0];
  assign pd_mode_b  = q.mode[1];
  assign shutdown_a = q.shdn[0];
  assign shutdown_b = q.shdn[1];
  assign frame_done = q.done;
  assign frame_drop = q.drop;

  // each falling serial clock inside a frame shifts in one bit, msb first
  property p_shift_in;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_SHIFT) && csn_low && sclk_fall
        |=> q.shf == {$past(q.shf[22:0]), $past(din_s)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register did not take the sampled data bit");

  // a locked frame keeps its bits and count whatever the clock does
  property p_locked_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_LOCK) |=> $stable(q.shf) && $stable(q.cnt) && !q.push;
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("locked shift register changed");

  // the 24th fall hands the frame over on the very next cycle
  property p_push_on_last;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_SHIFT) && csn_low && sclk_fall && (q.cnt == CNT_LAST)
        |=> q.push && (q.st == ST_LOCK) ##1 !q.push;
  endproperty
  a_push_on_last: assert property (p_push_on_last)
    else $error("complete frame was not handed over at once");

  // an early select rise empties the shifter and the count
  property p_abort_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_SHIFT) && !csn_low
        |=> (q.cnt == CNT_ZERO) && (q.shf == 24'h000000) && (q.st == ST_IDLE);
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("aborted frame left bits behind");

  // an aborted frame never reaches buffers or channels
  property p_abort_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_SHIFT) && !csn_low && !pop
        |=> !q.push && $stable(q.buf_data) && $stable(q.dac_code) && $stable(q.mode);
  endproperty
  a_abort_keep: assert property (p_abort_keep)
    else $error("aborted frame changed stored state");

  // a power command to buffer a keeps its sample and stores the code
  property p_pd_keeps_data;
    @(posedge clk_sys) disable iff (!rst_n)
      pop && (pcode != PD_NORMAL) && (buf_sel == SEL_CHAN_A)
        |=> $stable(q.buf_data[0]) && (q.buf_pd[0] == $past(pcode));
  endproperty
  a_pd_keeps_data: assert property (p_pd_keeps_data)
    else $error("power command disturbed the buffered sample");

  // the channel a code only moves on a load of channel a
  property p_code_only_on_load;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(q.dac_code[0]) || $changed(q.mode[0]) |-> $past(pop) && $past(load_chan_a_bit);
  endproperty
  a_code_only_on_load: assert property (p_code_only_on_load)
    else $error("channel a changed without a load");

  // channel b is untouched unless its own load bit is set
  property p_b_untouched;
    @(posedge clk_sys) disable iff (!rst_n)
      pop && !load_chan_b_bit |=> $stable(q.dac_code[1]) && $stable(q.mode[1]);
  endproperty
  a_b_untouched: assert property (p_b_untouched)
    else $error("channel b changed without its load");

  // a double load moves both channels from their own buffers in one cycle
  property p_dual_load;
    @(posedge clk_sys) disable iff (!rst_n)
      pop && load_chan_a_bit && load_chan_b_bit
        |=> (q.mode[0] == $past(nxt_pd[0])) && (q.mode[1] == $past(nxt_pd[1]))
            && (q.dac_code[0] == $past(nxt_data[0]))
            && (q.dac_code[1] == $past(nxt_data[1]));
  endproperty
  a_dual_load: assert property (p_dual_load)
    else $error("combined load did not update both channels");

  // shutdown follows the loaded power code of each channel
  property p_shutdown_tracks;
    @(posedge clk_sys) disable iff (!rst_n)
      (shutdown_a == (pd_mode_a != PD_NORMAL)) && (shutdown_b == (pd_mode_b != PD_NORMAL));
  endproperty
  a_shutdown_tracks: assert property (p_shutdown_tracks)
    else $error("shutdown disagrees with loaded power code");

  // channel a leaving power-down takes a zero code load on channel a
  property p_wake_needs_load;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(shutdown_a) |-> $past(pop) && $past(load_chan_a_bit) && (pd_mode_a == PD_NORMAL);
  endproperty
  a_wake_needs_load: assert property (p_wake_needs_load)
    else $error("channel a woke without a normal code load");

  // a held low select after a locked frame must not open another one
  property p_open_on_fall;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_IDLE) && !csn_fall |=> (q.st == ST_IDLE);
  endproperty
  a_open_on_fall: assert property (p_open_on_fall)
    else $error("frame opened without a select fall");

  // channel b only enters a power mode through a load of channel b
  property p_b_pd_needs_load;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(shutdown_b) |-> $past(pop) && $past(load_chan_b_bit) && (pd_mode_b != PD_NORMAL);
  endproperty
  a_b_pd_needs_load: assert property (p_b_pd_needs_load)
    else $error("channel b powered down without its load");

  // bits and count only move on a sampled serial clock fall inside a frame
  property p_cnt_moves_on_fall;
    @(posedge clk_sys) disable iff (!rst_n)
      (q.st == ST_SHIFT) && csn_low && !sclk_fall |=> $stable(q.cnt) && $stable(q.shf);
  endproperty
  a_cnt_moves_on_fall: assert property (p_cnt_moves_on_fall)
    else $error("shift register moved without a serial clock fall");

  // a write aimed at buffer a leaves buffer b exactly as it was
  property p_sel_a_spares_b;
    @(posedge clk_sys) disable iff (!rst_n)
      pop && (buf_sel == SEL_CHAN_A) |=> $stable(q.buf_data[1]) && $stable(q.buf_pd[1]);
  endproperty
  a_sel_a_spares_b: assert property (p_sel_a_spares_b)
    else $error("write to buffer a disturbed buffer b");

endmodule : ddc_core

`default_nettype wire

// *** ddc_host_model.sv ***
// host side serial master model that drives frames into the decoder
`timescale 1ns/10ps
`default_nettype none

module ddc_host_model (
  // pacing clock
  input  wire logic clk_sys,
  // serial link pins
  output logic      sclk,
  output logic      sync_n,
  output logic      sdin
);
  // four system cycles a half period gives the 800 ns link clock
  localparam int HALF = 4;

  // link idles with the clock still and select high
  initial begin
    sclk   = 1'b0;
    sync_n = 1'b1;
    sdin   = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  // nbits below 24 aborts the frame; extra adds clock edges past the 24th
  task automatic send_frame(input logic [23:0] w, input int nbits, input int extra);
    logic [23:0] f;
    f = {2'h0, w[21:0]};                          // reserved bits always zero
    sync_n = 1'b0;
    wait_cyc(HALF);
    for (int i = 23; i > 23 - nbits; i--) begin   // msb first, data set at rise
      sclk = 1'b1;
      sdin = f[i];
      wait_cyc(HALF);
      sclk = 1'b0;
      wait_cyc(HALF);
    end
    // select stays low across all nbits falls and any surplus edges
    repeat (extra) begin
      sclk = 1'b1;
      sdin = ~sdin;
      wait_cyc(HALF);
      sclk = 1'b0;
      wait_cyc(HALF);
    end
    // released data line must not keep its last value
    sdin   = ~sdin;
    sync_n = 1'b1;
    wait_cyc(2 * HALF);
  endtask : send_frame
endmodule : ddc_host_model
`default_nettype wire

// *** dual_dac_command_decoder_tb.sv ***
// self-checking testbench of the dual channel converter command decoder
`timescale 1ns/10ps
`default_nettype none

module dual_dac_command_decoder_tb
  import ddc_pkg::*;
;
  // small fifo so that a third held frame is refused
  localparam int DEPTH_T = 2;

  logic        clk_sys;
  logic        rst_n;
  logic        upd_hold;
  logic        sclk;
  logic        sync_n;
  logic        sdin;
  logic [15:0] dac_code_a;
  logic [15:0] dac_code_b;
  logic [1:0]  pd_mode_a;
  logic [1:0]  pd_mode_b;
  logic        shutdown_a;
  logic        shutdown_b;
  logic        frame_done;
  logic        frame_drop;
  logic        done_sync;
  int          n_mismatch;
  int          n_checks;
  int          n_done;
  int          n_drop;
  int          d0;
  // expected buffers and channel registers, index 0 is channel a
  logic [15:0] e_bd [2];
  logic [1:0]  e_bp [2];
  logic [15:0] e_dd [2];
  logic [1:0]  e_dp [2];

  ddc_core #(.DEPTH(DEPTH_T)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .upd_hold(upd_hold), .dac_code_a(dac_code_a), .pd_mode_a(pd_mode_a),
    .shutdown_a(shutdown_a), .dac_code_b(dac_code_b), .pd_mode_b(pd_mode_b),
    .shutdown_b(shutdown_b), .frame_done(frame_done), .frame_drop(frame_drop)
  );

  ddc_host_model host_u (.clk_sys(clk_sys), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // pulse counters; select level is kept to see when a frame completed
  always @(posedge clk_sys) begin
    if (frame_done === 1'b1) begin
      n_done++;
      done_sync <= sync_n;
    end
    if (frame_drop === 1'b1) n_drop++;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic check_all();
    chk("dac_code_a", e_dd[0], dac_code_a);
    chk("dac_code_b", e_dd[1], dac_code_b);
    chk("pd_mode_a", 16'(e_dp[0]), 16'(pd_mode_a));
    chk("pd_mode_b", 16'(e_dp[1]), 16'(pd_mode_b));
    chk("shutdown_a", 16'(e_dp[0] != PD_NORMAL), 16'(shutdown_a));
    chk("shutdown_b", 16'(e_dp[1] != PD_NORMAL), 16'(shutdown_b));
  endtask : check_all

  // buffer write of the selected side, then loads from each own buffer
  task automatic exp_apply(input logic [23:0] w);
    int s;
    s = int'(w[POS_BUF_SEL]);
    if (w[17:16] != PD_NORMAL) begin
      e_bp[s] = w[17:16];
    end else begin
      e_bd[s] = w[15:0];
      e_bp[s] = PD_NORMAL;
    end
    for (int c = 0; c < 2; c++) begin
      if (w[POS_LOAD_CHAN_A + c]) begin
        e_dd[c] = e_bd[c];
        e_dp[c] = e_bp[c];
      end
    end
  endtask : exp_apply

  // bounded wait for the decode pulse count to reach tgt
  task automatic wait_done(input int tgt);
    int k;
    k = 0;
    while (n_done < tgt && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    chk("frame_done_count", 16'(tgt), 16'(n_done));
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : wait_done

  task automatic frame(input logic [23:0] w, input int extra);
    int b;
    b = n_done;
    host_u.send_frame(w, 24, extra);
    exp_apply(w);
    wait_done(b + 1);
    check_all();
  endtask : frame

  // reset held two cycles; expectations return to power-up values with it
  task automatic pulse_reset();
    rst_n = 1'b0;
    e_bd  = '{RST_CODE, RST_CODE};
    e_dd  = '{RST_CODE, RST_CODE};
    e_bp  = '{RST_PCODE, RST_PCODE};
    e_dp  = '{RST_PCODE, RST_PCODE};
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog well beyond the expected 0.4 ms of traffic
  initial begin
    #2000000;
    n_mismatch++;
    $display("wrong value watchdog expected done seen hang");
    tally_and_finish();
  end

  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    n_done     = 0;
    n_drop     = 0;
    upd_hold   = 1'b0;
    pulse_reset();
    check_all();
    frame(24'h20_1234, 0);
    frame(24'h04_beef, 0);
    frame(24'h30_5a5a, 3);
    chk("sync_n_at_done", 16'h0000, 16'(done_sync));
    frame(24'h00_c3c3, 0);
    $display("test load_paths done");
    for (int pc = 1; pc < 4; pc++) frame({8'h10 | 8'(pc), 16'hffff}, 0);
    frame(24'h17_0000, 0);
    frame(24'h21_0000, 0);
    frame(24'h33_0000, 0);
    frame(24'h26_0000, 0);
    frame(24'h10_1111, 0);
    $display("test power_modes done");
    d0 = n_done;
    host_u.send_frame(24'h30_ffff, 23, 0);
    repeat (20) @(posedge clk_sys);
    #1;
    chk("abort_frame_done", 16'(d0), 16'(n_done));
    check_all();
    frame(24'h34_0abc, 0);
    $display("test abort done");
    upd_hold = 1'b1;
    d0       = n_drop;
    host_u.send_frame(24'h30_0101, 24, 0);
    host_u.send_frame(24'h24_0202, 24, 0);
    host_u.send_frame(24'h10_0303, 24, 0);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("frame_drop_count", 16'(d0 + 1), 16'(n_drop));
    check_all();
    d0 = n_done;
    exp_apply(24'h30_0101);
    exp_apply(24'h24_0202);
    upd_hold = 1'b0;
    wait_done(d0 + 2);
    check_all();
    $display("test queue done");
    pulse_reset();
    check_all();
    frame(24'h20_5555, 0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : dual_dac_command_decoder_tb
`default_nettype wire
